// file: rtl/spc_pkg.sv
// Constants, types and helpers shared by the preamble codec files
package spc_pkg;
    localparam int SPC_PAY_W = 28;
    localparam int SPC_BUF_DEPTH = 2;
    localparam logic [5:0] SPC_POS_FIRST = 6'h00;
    localparam logic [5:0] SPC_POS_DATA = 6'h08;
    localparam logic [4:0] SPC_SLOT_DATA = 5'h04;
    localparam logic [2:0] SPC_PRE_LAST = 3'h7;
    localparam logic [7:0] SPC_FRAME_FIRST = 8'h00;
    localparam logic [7:0] SPC_FRAME_LAST = 8'hbf;
    localparam logic [5:0] SPC_RX_LAST = 6'h37;
    localparam logic SPC_LINE_RST = 1'b0;
    // Patterns for a preceding line state of 0; invert for 1
    localparam logic [7:0] SPC_PRE_X = 8'he2;
    localparam logic [7:0] SPC_PRE_Y = 8'he4;
    localparam logic [7:0] SPC_PRE_Z = 8'he8;

    typedef enum logic [1:0] {SPC_KIND_X, SPC_KIND_Y, SPC_KIND_Z} spc_kind_t;
    typedef enum logic {SPC_RX_HUNT, SPC_RX_DATA} spc_rx_st_t;

    function automatic logic [7:0] spc_pattern(input spc_kind_t k);
        case (k)
            SPC_KIND_X: return SPC_PRE_X;
            SPC_KIND_Y: return SPC_PRE_Y;
            default: return SPC_PRE_Z;
        endcase
    endfunction

    // True when 8 states plus the one before could be legal bi-phase mark
    function automatic logic spc_bmc_legal(input logic [8:0] w);
        logic even_ok;
        logic odd_ok;
        even_ok = (w[8] != w[7]) && (w[6] != w[5]) && (w[4] != w[3]) &&
                  (w[2] != w[1]);
        odd_ok = (w[7] != w[6]) && (w[5] != w[4]) && (w[3] != w[2]) &&
                 (w[1] != w[0]);
        return even_ok || odd_ok;
    endfunction
endpackage

// file: rtl/spc_stream_if.sv
// Valid/ready word carrier between the codec's own modules
`timescale 1ns/1ns
interface spc_stream_if #(parameter int W = 28);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: rtl/spc_buf2.sv
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ns
module spc_buf2
    import spc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Filling and draining sides
    spc_stream_if.snk s_in,
    spc_stream_if.src s_out
);
    logic [SPC_PAY_W-1:0] mem_q [SPC_BUF_DEPTH];
    logic [SPC_PAY_W-1:0] mem_d [SPC_BUF_DEPTH];
    logic wr_q, wr_d, rd_q, rd_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    assign s_in.ready = (cnt_q != 2'(SPC_BUF_DEPTH));
    assign s_out.valid = (cnt_q != 2'h0);
    assign s_out.data = mem_q[rd_q];
    assign push = s_in.valid && s_in.ready;
    assign pop = s_out.valid && s_out.ready;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = s_in.data;
            wr_d = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        case ({push, pop})
            2'b10: cnt_d = cnt_q + 2'h1;
            2'b01: cnt_d = cnt_q - 2'h1;
            default: cnt_d = cnt_q;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    chk_buf_no_over: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (cnt_q == 2'h2 && !pop) |=> (cnt_q == 2'h2) && !s_in.ready &&
        (mem_q[0] == $past(mem_q[0])) && (mem_q[1] == $past(mem_q[1])))
        else $error("buffer accepts while full");
endmodule

// file: rtl/spc_codec.sv
// Preamble generator and detector for a bi-phase mark audio line
`timescale 1ns/1ns
// Functional notes
// - Preamble fills slots 0 to 3 as eight states, two per slot.
// - First preamble state opposes the last parity state.
// - Preceding 0 gives X 11100010, Y 11100100, Z 11101000.
// - Preceding 1 gives the inverted patterns 00011101, 00011011, 00010111.
// - Preambles break bi-phase coding, so violations mark sync.
// - Preambles differ from legal bi-phase; detector rejects legal sequences.
// - First subframe carries X, and Z once every 192 frames.
// - Second subframe always carries Y.
// - Slots 4 to 31 use bi-phase mark with boundary toggles.
module spc_codec
    import spc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Transmit payload, slots 4 to 31, slot 4 in bit 0
    input wire logic i_tx_valid,
    input wire logic [SPC_PAY_W-1:0] i_tx_data,
    output logic o_tx_ready,
    // Transmit line
    output logic o_tx_line,
    output spc_kind_t o_tx_kind,
    output logic o_tx_underrun,
    // Receive line
    input wire logic i_rx_line,
    // Receive results
    output logic o_rx_sync,
    output spc_kind_t o_rx_sync_kind,
    output logic o_rx_valid,
    output logic [SPC_PAY_W-1:0] o_rx_data,
    output spc_kind_t o_rx_kind,
    output logic o_rx_code_err
);
    spc_stream_if #(.W(SPC_PAY_W)) s_in ();
    spc_stream_if #(.W(SPC_PAY_W)) s_out ();

    assign s_in.valid = i_tx_valid;
    assign s_in.data = i_tx_data;
    assign o_tx_ready = s_in.ready;

    // Up to two words wait here, so a source stall starves a subframe edge only once both are sent
    spc_buf2 u_buf (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .s_in(s_in),
        .s_out(s_out)
    );

    // ---------------- Transmit ----------------
    logic [5:0] pos_q, pos_d;
    logic sub_q, sub_d;
    logic [7:0] frame_q, frame_d;
    logic [SPC_PAY_W-1:0] word_q, word_d;
    logic [7:0] pre_q, pre_d;
    logic line_q, line_d;
    logic under_q, under_d;
    spc_kind_t kind_q, kind_d, cur_kind;
    logic [7:0] pat;
    logic [4:0] bit_idx;

    // Ready only at a subframe start: one word per 64 states
    assign s_out.ready = (pos_q == SPC_POS_FIRST);
    assign bit_idx = pos_q[5:1] - SPC_SLOT_DATA;

    always_comb begin
        if (!sub_q) begin
            cur_kind = (frame_q == SPC_FRAME_FIRST) ? SPC_KIND_Z : SPC_KIND_X;
        end else begin
            cur_kind = SPC_KIND_Y;
        end
        // base patterns, inverted after a high state
        pat = spc_pattern(cur_kind) ^ {8{line_q}};
    end

    always_comb begin
        pos_d = pos_q + 6'h01;
        sub_d = sub_q;
        frame_d = frame_q;
        word_d = word_q;
        pre_d = pre_q;
        kind_d = kind_q;
        under_d = 1'b0;
        if (pos_q == SPC_POS_FIRST) begin
            // first state opposes parity end via pattern choice
            pre_d = pat;
            line_d = pat[7];
            kind_d = cur_kind;
            sub_d = ~sub_q;
            if (sub_q) begin
                frame_d = (frame_q == SPC_FRAME_LAST) ? SPC_FRAME_FIRST :
                          frame_q + 8'h01;
            end
            // An empty buffer sends a zero word, which keeps even parity
            if (s_out.valid) begin
                word_d = s_out.data;
            end else begin
                word_d = '0;
                under_d = 1'b1;
            end
        end else if (pos_q < SPC_POS_DATA) begin
            line_d = pre_q[SPC_PRE_LAST - pos_q[2:0]];
        end else if (!pos_q[0]) begin
            line_d = ~line_q;
        end else begin
            line_d = word_q[bit_idx] ? ~line_q : line_q;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pos_q <= SPC_POS_FIRST;
            sub_q <= 1'b0;
            frame_q <= SPC_FRAME_FIRST;
            word_q <= '0;
            pre_q <= 8'h00;
            line_q <= SPC_LINE_RST;
            kind_q <= SPC_KIND_X;
            under_q <= 1'b0;
        end else begin
            pos_q <= pos_d;
            sub_q <= sub_d;
            frame_q <= frame_d;
            word_q <= word_d;
            pre_q <= pre_d;
            line_q <= line_d;
            kind_q <= kind_d;
            under_q <= under_d;
        end
    end

    assign o_tx_line = line_q;
    assign o_tx_kind = kind_q;
    assign o_tx_underrun = under_q;

    // ---------------- Receive ----------------
    spc_rx_st_t st_q, st_d;
    logic [8:0] win_q, win_d;
    logic [5:0] cnt_q, cnt_d;
    logic [SPC_PAY_W-1:0] shf_q, shf_d;
    logic err_q, err_d;
    spc_kind_t hk_q, hk_d, hit_kind;
    logic hit, match;
    logic sync_q, sync_d, val_q, val_d;
    logic [SPC_PAY_W-1:0] data_q, data_d;
    spc_kind_t rk_q, rk_d;
    logic rerr_q, rerr_d;

    always_comb begin
        match = 1'b1;
        hit_kind = SPC_KIND_X;
        if (win_q[7:0] == (SPC_PRE_X ^ {8{win_q[8]}})) begin
            hit_kind = SPC_KIND_X;
        end else if (win_q[7:0] == (SPC_PRE_Y ^ {8{win_q[8]}})) begin
            hit_kind = SPC_KIND_Y;
        end else if (win_q[7:0] == (SPC_PRE_Z ^ {8{win_q[8]}})) begin
            hit_kind = SPC_KIND_Z;
        end else begin
            match = 1'b0;
        end
        // legal bi-phase windows are never taken
        hit = (st_q == SPC_RX_HUNT) && match && !spc_bmc_legal(win_q);
    end

    always_comb begin
        win_d = {win_q[7:0], i_rx_line};
        st_d = st_q;
        cnt_d = cnt_q;
        shf_d = shf_q;
        err_d = err_q;
        hk_d = hk_q;
        sync_d = 1'b0;
        val_d = 1'b0;
        data_d = data_q;
        rk_d = rk_q;
        rerr_d = rerr_q;
        case (st_q)
            SPC_RX_HUNT: begin
                if (hit) begin
                    st_d = SPC_RX_DATA;
                    cnt_d = 6'h00;
                    err_d = 1'b0;
                    hk_d = hit_kind;
                    sync_d = 1'b1;
                end
            end
            SPC_RX_DATA: begin
                cnt_d = cnt_q + 6'h01;
                if (!cnt_q[0]) begin
                    // missing boundary toggle is a code error
                    if (win_q[0] == win_q[1]) begin
                        err_d = 1'b1;
                    end
                end else begin
                    shf_d = {win_q[0] ^ win_q[1], shf_q[SPC_PAY_W-1:1]};
                end
                if (cnt_q == SPC_RX_LAST) begin
                    st_d = SPC_RX_HUNT;
                    val_d = 1'b1;
                    data_d = shf_d;
                    rk_d = hk_q;
                    rerr_d = err_d;
                end
            end
            default: st_d = SPC_RX_HUNT;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= SPC_RX_HUNT;
            win_q <= 9'h000;
            cnt_q <= 6'h00;
            shf_q <= '0;
            err_q <= 1'b0;
            hk_q <= SPC_KIND_X;
            sync_q <= 1'b0;
            val_q <= 1'b0;
            data_q <= '0;
            rk_q <= SPC_KIND_X;
            rerr_q <= 1'b0;
        end else begin
            st_q <= st_d;
            win_q <= win_d;
            cnt_q <= cnt_d;
            shf_q <= shf_d;
            err_q <= err_d;
            hk_q <= hk_d;
            sync_q <= sync_d;
            val_q <= val_d;
            data_q <= data_d;
            rk_q <= rk_d;
            rerr_q <= rerr_d;
        end
    end

    assign o_rx_sync = sync_q;
    assign o_rx_sync_kind = hk_q;
    assign o_rx_valid = val_q;
    assign o_rx_data = data_q;
    assign o_rx_kind = rk_q;
    assign o_rx_code_err = rerr_q;

    // ---------------- Checks ----------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence seq_x_low;
        line_q ##1 line_q ##1 line_q ##1 !line_q ##1 !line_q ##1 !line_q
        ##1 line_q ##1 !line_q;
    endsequence
    sequence seq_z_high;
        !line_q ##1 !line_q ##1 !line_q ##1 line_q ##1 !line_q ##1 line_q
        ##1 line_q ##1 line_q;
    endsequence

    chk_pre_first_flip: assert property (
        (pos_q == SPC_POS_FIRST) |=> (line_q != $past(line_q)))
        else $error("preamble start does not oppose parity end");
    chk_pattern_x_low: assert property (
        (pos_q == SPC_POS_FIRST && !line_q && cur_kind == SPC_KIND_X)
        |=> seq_x_low)
        else $error("wrong X pattern after low state");
    chk_pattern_z_high: assert property (
        (pos_q == SPC_POS_FIRST && line_q && cur_kind == SPC_KIND_Z)
        |=> seq_z_high)
        else $error("wrong Z pattern after high state");
    chk_pre_eight_states: assert property (
        (pos_q == SPC_POS_FIRST) |-> ##8 (pos_q == SPC_POS_DATA))
        else $error("preamble does not span eight states");
    chk_block_start_z: assert property (
        (pos_q == SPC_POS_FIRST && !sub_q) |=>
        (kind_q == (($past(frame_q) == SPC_FRAME_FIRST) ? SPC_KIND_Z :
                    SPC_KIND_X)))
        else $error("first subframe marker wrong");
    chk_second_is_y: assert property (
        (pos_q == SPC_POS_FIRST && sub_q) |=> (kind_q == SPC_KIND_Y))
        else $error("second subframe marker is not Y");
    chk_bit_boundary: assert property (
        (pos_q >= SPC_POS_DATA && !pos_q[0]) |=> (line_q != $past(line_q)))
        else $error("no toggle at bit boundary");
    chk_shift_order: assert property (
        (pos_q == SPC_POS_FIRST) |=> (line_q == pre_q[7]) ##1
        (line_q == $past(pre_q[6])))
        else $error("preamble not sent leftmost first");
    chk_rx_reject_legal: assert property (
        $rose(o_rx_sync) |-> !spc_bmc_legal($past(win_q)) &&
        ($past(win_q[8]) != $past(win_q[7])))
        else $error("sync taken on a legal bi-phase window");
    chk_rx_frame_len: assert property (
        o_rx_sync |-> ##56 o_rx_valid)
        else $error("payload not delivered 56 cycles after sync");
endmodule

// file: verification/spc_far_tx.sv
// Remote line transmitter model that drives the codec's receive line
`timescale 1ns/1ns
module spc_far_tx
    import spc_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Line towards the codec
    output logic o_line
);
    logic q[$];

    initial o_line = 1'b0;

    // Idle line toggles every state, so a stale level never poses as data
    always @(negedge i_clk) begin
        if (q.size() > 0) begin
            o_line <= q.pop_front();
        end else begin
            o_line <= ~o_line;
        end
    end

    // Line states of one subframe, first state in bit 63
    function automatic logic [63:0] states(input spc_kind_t k,
            input logic [SPC_PAY_W-1:0] d, input logic prev, input logic bad);
        logic [63:0] v;
        logic s;
        // patterns break the coding on purpose
        v[63:56] = ((k == SPC_KIND_X) ? SPC_PRE_X :
            (k == SPC_KIND_Y) ? SPC_PRE_Y : SPC_PRE_Z) ^ {8{prev}};
        s = v[56];
        // boundary toggle, mid-cell toggle for a one
        for (int b = 0; b < SPC_PAY_W; b++) begin
            if (!(bad && b == 5)) begin
                s = ~s;
            end
            v[55-2*b] = s;
            if (d[b]) begin
                s = ~s;
            end
            v[54-2*b] = s;
        end
        return v;
    endfunction

    // Queue one subframe; bad drops the boundary toggle before bit 5
    task automatic send(input spc_kind_t k, input logic [SPC_PAY_W-1:0] d,
            input logic bad);
        logic [63:0] v;
        v = states(k, d, (q.size() > 0) ? q[$] : o_line, bad);
        for (int i = 63; i >= 0; i--) begin
            q.push_back(v[i]);
        end
    endtask
endmodule

// file: verification/spc_codec_tb.sv
// Self-checking testbench for the preamble codec
`timescale 1ns/1ns
module spc_codec_tb
    import spc_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_tx_valid = 1'b0;
    logic [SPC_PAY_W-1:0] i_tx_data = '0;
    logic rx_line;
    logic o_tx_ready;
    logic o_tx_line;
    spc_kind_t o_tx_kind;
    logic o_tx_underrun;
    logic o_rx_sync;
    spc_kind_t o_rx_sync_kind;
    logic o_rx_valid;
    logic [SPC_PAY_W-1:0] o_rx_data;
    spc_kind_t o_rx_kind;
    logic o_rx_code_err;
    int err_total = 0;
    int checks_done = 0;
    int sync_seen = 0;

    always #2 i_clk = ~i_clk;

    spc_codec spc_codec_inst (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data),
        .o_tx_ready(o_tx_ready), .o_tx_line(o_tx_line),
        .o_tx_kind(o_tx_kind), .o_tx_underrun(o_tx_underrun),
        .i_rx_line(rx_line), .o_rx_sync(o_rx_sync),
        .o_rx_sync_kind(o_rx_sync_kind), .o_rx_valid(o_rx_valid),
        .o_rx_data(o_rx_data), .o_rx_kind(o_rx_kind),
        .o_rx_code_err(o_rx_code_err)
    );

    spc_far_tx spc_far_tx_inst (.i_clk(i_clk), .o_line(rx_line));

    always @(negedge i_clk) begin
        if (o_rx_sync === 1'b1) begin
            sync_seen++;
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Three words through the buffer while 193 frames (386 subframes) of line output are checked
    task automatic tx_stream();
        logic [SPC_PAY_W-1:0] w[3];
        logic [SPC_PAY_W-1:0] d;
        logic [63:0] got;
        logic [63:0] exp;
        logic prev;
        spc_kind_t k;
        // Even, odd, even ones: X is seen after both line polarities
        w[0] = 28'hfffffff;
        w[1] = 28'h0a5c3f1;
        w[2] = 28'h8000001;
        prev = SPC_LINE_RST;
        fork
            begin
                for (int n = 0; n < 3; n++) begin
                    i_tx_valid = 1'b1;
                    i_tx_data = w[n];
                    while (o_tx_ready !== 1'b1) @(negedge i_clk);
                    @(negedge i_clk);
                    if (n == 1) chk(o_tx_ready, 1'b0);
                end
                i_tx_valid = 1'b0;
            end
            begin
                // State 0 stands from the edge after release onwards
                for (int sf = 0; sf < 386; sf++) begin
                    k = (sf % 2 == 1) ? SPC_KIND_Y :
                        (sf % 384 == 0) ? SPC_KIND_Z : SPC_KIND_X;
                    d = (sf >= 1 && sf <= 3) ? w[sf-1] : '0;
                    for (int i = 0; i < 64; i++) begin
                        @(negedge i_clk);
                        got[63-i] = o_tx_line;
                        if (i == 0) begin
                            chk(o_tx_kind, k);
                            chk(o_tx_underrun, (sf == 0 || sf > 3));
                        end
                    end
                    exp = spc_far_tx_inst.states(k, d, prev, 1'b0);
                    chk(got, exp);
                    prev = exp[0];
                end
            end
        join
    endtask

    // Wait for one received subframe and judge its results
    task automatic rx_check(input spc_kind_t k,
            input logic [SPC_PAY_W-1:0] d, input logic bad);
        int n;
        n = 0;
        while (o_rx_sync !== 1'b1 && n < 150) begin
            @(negedge i_clk);
            n++;
        end
        chk(o_rx_sync, 1'b1);
        chk(o_rx_sync_kind, k);
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_rx_valid !== 1'b1 && n < 70);
        chk(n, 56);
        chk(o_rx_data, d);
        chk(o_rx_kind, k);
        chk(o_rx_code_err, bad);
    endtask

    initial begin
        repeat (12) @(negedge i_clk);
        i_sys_rst = 1'b0;
        tx_stream();
        // Long toggling idle is legal coding and must never sync
        chk(sync_seen, 0);
        @(posedge i_clk);
        spc_far_tx_inst.send(SPC_KIND_Z, 28'h1234567, 1'b0);
        spc_far_tx_inst.send(SPC_KIND_Y, 28'hedcba98, 1'b0);
        rx_check(SPC_KIND_Z, 28'h1234567, 1'b0);
        rx_check(SPC_KIND_Y, 28'hedcba98, 1'b0);
        @(posedge i_clk);
        spc_far_tx_inst.send(SPC_KIND_X, 28'h0f0f0f0, 1'b1);
        rx_check(SPC_KIND_X, 28'h0f0f0f0, 1'b1);
        close_out();
    end

    // Tests need about 25000 cycles
    initial begin
        repeat (40000) @(posedge i_clk);
        err_total++;
        close_out();
    end
endmodule
